// ===== amx_regs.svh
// register offsets, field positions, reset values and timing counts for the converter control
`ifndef AMX_REGS_SVH
`define AMX_REGS_SVH

`define AMX_ADDR_W        4
`define AMX_DATA_W        16
`define AMX_PINS          8
`define AMX_RES_W         12
`define AMX_RES_CODES     4096

`define AMX_OFF_CTRL      4'h0
`define AMX_OFF_STATUS    4'h1
`define AMX_OFF_MUX       4'h2
`define AMX_OFF_DIR       4'h3
`define AMX_OFF_DATA      4'h4
`define AMX_OFF_RESULT    4'h5
`define AMX_OFF_SETTLE    4'h6

`define AMX_CTRL_CORE     0
`define AMX_CTRL_REF      1
`define AMX_CTRL_BG       2

`define AMX_STS_MODE_LSB  0
`define AMX_STS_READY     4
`define AMX_STS_DROP      5

`define AMX_CTRL_RST      3'h0
`define AMX_MUX_RST       8'hFF
`define AMX_DIR_RST       8'h00
`define AMX_DATA_RST      8'h00

`define AMX_CLK_PERIOD_NS 100
`define AMX_SETTLE_NS     1000000
`define AMX_SETTLE_CYC    (`AMX_SETTLE_NS / `AMX_CLK_PERIOD_NS)

`endif

// ===== amx_pkg.sv
// types shared by the converter control files
package amx_pkg;
    typedef enum logic [3:0] {
        AMX_MODE_OFF   = 4'h1,
        AMX_MODE_COMP  = 4'h2,
        AMX_MODE_QUICK = 4'h4,
        AMX_MODE_FULL  = 4'h8
    } amx_mode_e;
endpackage

// ===== amx_settle_timer.sv
// power-up stabilisation down-counter with ready flag
`include "amx_regs.svh"
module amx_settle_timer
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // control
    input  wire logic                   load_i,
    input  wire logic                   clear_i,
    input  wire logic [`AMX_DATA_W-1:0] count_i,
    // status
    output logic                        ready_o
);
    logic [`AMX_DATA_W-1:0] cnt_r;
    logic                   run_r;

    // load wins over clear: a fresh power-up write restarts the wait
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end
        else if (load_i)
        begin
            cnt_r <= count_i;                          // see [RULE_13]
            run_r <= 1'b1;
        end
        else if (clear_i)
        begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end
        else if (run_r && cnt_r != '0)
        begin
            cnt_r <= cnt_r - `AMX_DATA_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ready_o <= 1'b0;
        else if (load_i || clear_i)
            ready_o <= 1'b0;
        else if (run_r && cnt_r <= `AMX_DATA_W'(1))
            ready_o <= 1'b1;                           // see [RULE_13]
    end
endmodule

// ===== amx_ctrl.sv
// converter power-mode control, settle wait and shared analog pin mux
//
// Notes on behaviour
// [RULE_01] result is a 12-bit code, one step equals full scale over 4096
// [RULE_02] all three power bits set gives full mode, all clear gives off
// [RULE_03] bandgap and reference on, core off gives quick-wake mode
// [RULE_04] only bandgap on gives comparator-only mode, no conversions
// [RULE_05] conversions are not valid until the power-up settle delay has passed
// [RULE_06] all three power bits may be set in one write; wait counts from it
// [RULE_07] converter channel and comparator paths stay available regardless of mux
// [RULE_08] mux bit 0 enables digital function; data reads return pin level
// [RULE_09] mux bit 1 makes data reads return the stored output latch
// [RULE_10] deselected digital function gates off the pin input buffer
// [RULE_11] after reset every shared pin has its digital function disabled
// [RULE_12] software should keep digital function off on pins used as analog
// [RULE_13] settle wait is a loadable cycle counter that raises a ready flag
`include "amx_regs.svh"
module amx_ctrl
#(
    parameter logic [`AMX_DATA_W-1:0] SETTLE_CYCLES = `AMX_DATA_W'(`AMX_SETTLE_CYC)
)
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // register port
    input  wire logic [`AMX_ADDR_W-1:0] addr_i,
    input  wire logic [`AMX_DATA_W-1:0] wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic [`AMX_DATA_W-1:0]      rdata_o,
    // converter core
    input  wire logic                   conv_valid_i,
    input  wire logic [`AMX_RES_W-1:0]  conv_data_i,
    output logic                        bg_en_o,
    output logic                        ref_en_o,
    output logic                        core_en_o,
    output logic                        conv_allow_o,
    output logic                        comp_en_o,
    output logic [3:0]                  mode_o,
    // shared pins
    input  wire logic [`AMX_PINS-1:0]   pin_in_i,
    output logic [`AMX_PINS-1:0]        pin_out_o,
    output logic [`AMX_PINS-1:0]        pin_oe_o,
    output logic [`AMX_PINS-1:0]        pin_dig_in_o,
    output logic [`AMX_PINS-1:0]        pin_ana_en_o
);
    logic [2:0]                 ctrl_r;
    logic [2:0]                 ctrl_nxt;
    logic [`AMX_PINS-1:0]       mux_r;
    logic [`AMX_PINS-1:0]       dir_r;
    logic [`AMX_PINS-1:0]       latch_r;
    logic [`AMX_RES_W-1:0]      result_r;
    logic                       drop_r;
    logic [`AMX_DATA_W-1:0]     settle_r;
    amx_pkg::amx_mode_e         mode_r;
    logic                       ready;
    logic                       ctrl_wr;
    logic                       enter_full;
    logic                       leave_full;
    logic [`AMX_PINS-1:0]       pin_rd;

    // unlisted bit patterns have no defined mode; core stays unpowered there
    function automatic amx_pkg::amx_mode_e decode_mode(input logic [2:0] c);
        amx_pkg::amx_mode_e m;
        m = amx_pkg::AMX_MODE_OFF;
        case (c)
            3'h7:    m = amx_pkg::AMX_MODE_FULL;       // see [RULE_02]
            3'h6:    m = amx_pkg::AMX_MODE_QUICK;      // see [RULE_03]
            3'h4:    m = amx_pkg::AMX_MODE_COMP;       // see [RULE_04]
            3'h0:    m = amx_pkg::AMX_MODE_OFF;        // see [RULE_02]
            default: m = amx_pkg::AMX_MODE_OFF;
        endcase
        return m;
    endfunction

    assign ctrl_wr  = wr_i && addr_i == `AMX_OFF_CTRL;
    assign ctrl_nxt = ctrl_wr ? wdata_i[2:0] : ctrl_r;

    // all three bits may arrive in one write; the wait starts from that write
    assign enter_full = ctrl_wr && decode_mode(ctrl_nxt) == amx_pkg::AMX_MODE_FULL
                        && mode_r != amx_pkg::AMX_MODE_FULL;          // see [RULE_06]
    assign leave_full = ctrl_wr && decode_mode(ctrl_nxt) != amx_pkg::AMX_MODE_FULL;

    amx_settle_timer u_settle
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (enter_full),
        .clear_i (leave_full),
        .count_i (settle_r),
        .ready_o (ready)
    );

    // power control bits
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= `AMX_CTRL_RST;
            mode_r <= amx_pkg::AMX_MODE_OFF;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            mode_r <= decode_mode(ctrl_nxt);
        end
    end

    // settle count, reloadable so slower analog parts can be covered
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            settle_r <= SETTLE_CYCLES;
        else if (wr_i && addr_i == `AMX_OFF_SETTLE)
            settle_r <= wdata_i;                        // see [RULE_13]
    end

    // pin mux, direction and output latch
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mux_r   <= `AMX_MUX_RST;                    // see [RULE_11]
            dir_r   <= `AMX_DIR_RST;
            latch_r <= `AMX_DATA_RST;
        end
        else if (wr_i)
        begin
            if (addr_i == `AMX_OFF_MUX)
                mux_r <= wdata_i[`AMX_PINS-1:0];
            if (addr_i == `AMX_OFF_DIR)
                dir_r <= wdata_i[`AMX_PINS-1:0];
            if (addr_i == `AMX_OFF_DATA)
                latch_r <= wdata_i[`AMX_PINS-1:0];
        end
    end

    // only samples taken after the settle wait count as results
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            result_r <= '0;
        else if (conv_valid_i && conv_allow_o)
            result_r <= conv_data_i;                    // see [RULE_01]
    end

    // sticky drop flag; a new drop in the clearing cycle still sets it
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            drop_r <= 1'b0;
        else if (conv_valid_i && !conv_allow_o)
            drop_r <= 1'b1;                             // see [RULE_05]
        else if (wr_i && addr_i == `AMX_OFF_STATUS && wdata_i[`AMX_STS_DROP])
            drop_r <= 1'b0;
    end

    genvar g;
    generate
        for (g = 0; g < `AMX_PINS; g++)
        begin : g_pin
            // analog input stays buffered off the digital side to keep noise out
            assign pin_dig_in_o[g] = pin_in_i[g] & ~mux_r[g];         // see [RULE_10]
            assign pin_rd[g]       = mux_r[g] ? latch_r[g] : pin_in_i[g]; // see [RULE_08] [RULE_09]
            assign pin_oe_o[g]     = dir_r[g] & ~mux_r[g];            // see [RULE_08]
            assign pin_out_o[g]    = latch_r[g];
            assign pin_ana_en_o[g] = 1'b1;                            // see [RULE_07]
        end
    endgenerate

    assign bg_en_o      = ctrl_r[`AMX_CTRL_BG];
    assign ref_en_o     = ctrl_r[`AMX_CTRL_REF];
    assign core_en_o    = mode_r == amx_pkg::AMX_MODE_FULL;
    assign comp_en_o    = bg_en_o;                                    // see [RULE_04]
    assign conv_allow_o = core_en_o && ready;                         // see [RULE_05]
    assign mode_o       = mode_r;

    // read data, one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_o <= '0;
        else if (rd_i)
        begin
            case (addr_i)
                `AMX_OFF_CTRL:   rdata_o <= {13'h0000, ctrl_r};
                `AMX_OFF_STATUS: rdata_o <= {10'h000, drop_r, ready, mode_r};
                `AMX_OFF_MUX:    rdata_o <= {8'h00, mux_r};
                `AMX_OFF_DIR:    rdata_o <= {8'h00, dir_r};
                `AMX_OFF_DATA:   rdata_o <= {8'h00, pin_rd};
                `AMX_OFF_RESULT: rdata_o <= {4'h0, result_r};
                `AMX_OFF_SETTLE: rdata_o <= settle_r;
                default:         rdata_o <= '0;
            endcase
        end
        else
            rdata_o <= '0;
    end
endmodule

// ===== amx_ctrl_sva.sv
// port assertions for the converter control block
module amx_ctrl_sva
#(
    parameter logic [15:0] SETTLE_CYCLES = 16'h0008
)
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // watched ports
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        bg_en_o,
    input wire logic        ref_en_o,
    input wire logic        core_en_o,
    input wire logic        conv_allow_o,
    input wire logic        comp_en_o,
    input wire logic [3:0]  mode_o,
    input wire logic [7:0]  pin_in_i,
    input wire logic [7:0]  pin_oe_o,
    input wire logic [7:0]  pin_dig_in_o,
    input wire logic [7:0]  pin_ana_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] wait_r;
    // counter, since a long settle would unroll badly
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            wait_r <= 16'h0000;
        else if (core_en_o && !conv_allow_o)
            wait_r <= wait_r + 16'h0001;
        else
            wait_r <= 16'h0000;
    end
    full_mode_a: assert property (core_en_o == (mode_o == 4'h8))
        else $error("core power outside full mode");
    quick_mode_a: assert property (mode_o == 4'h4 |-> bg_en_o && ref_en_o)
        else $error("quick mode without bandgap and reference");
    comp_only_a: assert property (mode_o == 4'h2 |-> bg_en_o && !ref_en_o)
        else $error("comparator mode power wrong");
    comp_use_a: assert property (comp_en_o == bg_en_o)
        else $error("comparators not tied to bandgap");
    settle_hold_a: assert property ($rose(core_en_o) |-> !conv_allow_o [*4])
        else $error("conversions opened before settle");
    settle_end_a: assert property (wait_r <= SETTLE_CYCLES + 16'h0002)
        else $error("settle wait overran");
    allow_full_a: assert property (conv_allow_o |-> core_en_o)
        else $error("conversions allowed outside full mode");
    gate_in_a: assert property ((pin_dig_in_o & ~pin_in_i) == 8'h00)
        else $error("digital input not a gated pin level");
    ana_path_a: assert property (pin_ana_en_o == 8'hFF)
        else $error("analog path lost");
    reset_off_a: assert property ($fell(rst_i) |-> pin_oe_o == 8'h00 && mode_o == 4'h1)
        else $error("reset state wrong");
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside answer cycle");
    cover property ($rose(conv_allow_o));
    cover property (mode_o == 4'h2);
    cover property ($rose(rd_i));
endmodule

bind amx_ctrl amx_ctrl_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (.clk_i, .rst_i, .rd_i,
    .rdata_o, .bg_en_o, .ref_en_o, .core_en_o, .conv_allow_o, .comp_en_o, .mode_o,
    .pin_in_i, .pin_oe_o, .pin_dig_in_o, .pin_ana_en_o);

// ===== test_adc_power_and_aio_mux_control.sv
// register level bench for the converter control block
`include "amx_regs.svh"
module test_adc_power_and_aio_mux_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0, rst_i = 1'b1, wr_i, rd_i, conv_valid_i;
    logic        bg_en_o, ref_en_o, core_en_o, conv_allow_o, comp_en_o;
    logic [3:0]  addr_i, mode_o;
    logic [15:0] wdata_i, rdata_o;
    logic [11:0] conv_data_i;
    logic [7:0]  pin_in_i, pin_out_o, pin_oe_o, pin_dig_in_o, pin_ana_en_o;
    int          mismatches = 0, n_tests = 0, n;
    logic [15:0] ctl_t [4] = '{16'h0004, 16'h0006, 16'h0000, 16'h0007};
    logic [15:0] mod_t [4] = '{16'h0002, 16'h0004, 16'h0001, 16'h0008};
    logic [15:0] rst_t [8] = '{16'h0000, 16'h0001, 16'h00FF, 16'h0000,
                               16'h0000, 16'h0000, 16'h0008, 16'h0000};
    always #50 clk_i = ~clk_i;
    amx_ctrl #(.SETTLE_CYCLES(16'h0008)) dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .conv_valid_i, .conv_data_i, .bg_en_o, .ref_en_o, .core_en_o,
        .conv_allow_o, .comp_en_o, .mode_o, .pin_in_i, .pin_out_o, .pin_oe_o,
        .pin_dig_in_o, .pin_ana_en_o);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask
    task automatic conv(input logic [11:0] d);
        @(posedge clk_i);
        conv_valid_i <= 1'b1;
        conv_data_i <= d;
        @(posedge clk_i);
        conv_valid_i <= 1'b0;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        conv_valid_i = 1'b0;
        conv_data_i = 12'h000;
        pin_in_i = 8'h3C;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(4'(i), rst_t[i]);
        check(16'(pin_oe_o | pin_dig_in_o), 16'h0000);
        check(16'(pin_ana_en_o), 16'h00FF);
        for (int i = 0; i < 4; i++)
        begin
            wr(`AMX_OFF_CTRL, ctl_t[i]);
            check(16'(mode_o), mod_t[i]);
            check(16'({bg_en_o, ref_en_o, core_en_o}), ctl_t[i]);
            check(16'(comp_en_o), 16'(ctl_t[i][2]));
            check(16'(conv_allow_o), 16'h0000);
        end
        // last step went from off to full in one write
        n = 1;
        while (conv_allow_o !== 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check(16'(n >= 6 && n <= 11), 16'h0001);
        if (n >= 40)
            summarize();
        rd(`AMX_OFF_STATUS, 16'h0018);
        conv(12'hABC);
        rd(`AMX_OFF_RESULT, 16'h0ABC);
        wr(`AMX_OFF_CTRL, 16'h0006);
        check(16'(conv_allow_o), 16'h0000);
        conv(12'h123);
        rd(`AMX_OFF_RESULT, 16'h0ABC);
        rd(`AMX_OFF_STATUS, 16'h0024);
        wr(`AMX_OFF_STATUS, 16'h0020);
        rd(`AMX_OFF_STATUS, 16'h0004);
        wr(`AMX_OFF_DIR, 16'h00FF);
        wr(`AMX_OFF_DATA, 16'h005A);
        // pins 0 to 3 act as analog inputs, digital kept off
        wr(`AMX_OFF_MUX, 16'h000F);
        check(16'(pin_oe_o), 16'h00F0);
        check(16'(pin_dig_in_o), 16'h0030);
        check(16'(pin_out_o), 16'h005A);
        rd(`AMX_OFF_DATA, 16'h003A);
        summarize();
    end
endmodule
